// ### hdl/fchd_pkg.sv
// package of constants and types for the full-closed hybrid deviation block
package fchd_pkg;
   // configuration field widths
   localparam int TYPE_W = 3;               // scale type select, 0 to 6
   localparam int DIR_W = 2;                // direction inversion, 0 to 3
   localparam int RATIO_W = 24;             // numerator / denominator, up to 2^23
   localparam int GAP_W = 28;               // gap limit, up to 2^27
   localparam int REVS_W = 7;               // clear revolutions, 0 to 100
   localparam int POS_W = 32;               // position counter width
   localparam int PROD_W = POS_W + RATIO_W; // product width for ratio
   // range limits
   localparam logic [TYPE_W-1:0] TYPE_MAX = 3'h6;
   localparam logic [RATIO_W-1:0] RATIO_MAX = 24'h80_0000;
   localparam logic [GAP_W-1:0] GAP_MAX = 28'h800_0000;
   localparam logic [GAP_W-1:0] GAP_MIN = 28'h000_0001;
   localparam logic [REVS_W-1:0] REVS_MAX = 7'h64;
   // scale types: bit 0 clear selects quadrature, set selects serial
   localparam logic [TYPE_W-1:0] TYPE_QUAD = 3'h0;
   localparam int TYPE_SERIAL_BIT = 0;
   // direction inversion bits
   localparam int DIR_COUNT_BIT = 0;        // inverts scale count
   localparam int DIR_FEED_BIT = 1;         // inverts feedback counter output
   // quadrature input limit: 4 Mpulse/s means 250 ns per edge
   localparam int QUAD_EDGE_NS = 250;
   localparam int CLK_NS = 4;
   localparam int QUAD_EDGE_CYC = QUAD_EDGE_NS / CLK_NS;
   // reset values
   localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
   localparam logic [1:0] QUAD_RESET = 2'h0;
   // divider sequencer states, one bit changing from IDLE to RUN to DONE, two bits from DONE back to IDLE
   typedef enum logic [1:0] {
      DIV_IDLE = 2'b00,
      DIV_RUN = 2'b01,
      DIV_DONE = 2'b11
   } fchd_div_state_type;
endpackage

// ### hdl/fchd_ratio_if.sv
// interface carrying ratio divide requests between the top and the divider
`timescale 1ns/1ns
interface fchd_ratio_if;
   logic start;                                    // one-cycle request
   logic signed [fchd_pkg::PROD_W-1:0] dividend;  // scaled product
   logic [fchd_pkg::RATIO_W-1:0] divisor;          // denominator
   logic done;                                     // one-cycle completion
   logic signed [fchd_pkg::POS_W-1:0] quotient;    // converted position
   modport requester (output start, output dividend, output divisor, input done, input quotient);
   modport divider (input start, input dividend, input divisor, output done, output quotient);
endinterface

// ### hdl/fchd_ratio_div.sv
// sequential signed divider that turns scale counts into encoder units
`timescale 1ns/1ns
module fchd_ratio_div (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request channel
   fchd_ratio_if.divider req
);
   localparam int W = fchd_pkg::PROD_W;
   localparam logic [6:0] STEPS = 7'(W);
   fchd_pkg::fchd_div_state_type state_q, state_d;   // sequencer state
   logic [W-1:0] rem_q, rem_d;                       // partial remainder
   logic [W-1:0] quo_q, quo_d;                       // quotient shift
   logic [6:0] cnt_q, cnt_d;                         // step counter
   logic neg_q, neg_d;                               // result sign
   logic [fchd_pkg::POS_W-1:0] res_q, res_d;         // held quotient
   logic done_q, done_d;                             // completion pulse
   logic [W:0] trial;                                // trial subtract

   // next-state: restoring division one bit per cycle on magnitudes
   always_comb begin
      state_d = state_q;
      rem_d = rem_q;
      quo_d = quo_q;
      cnt_d = cnt_q;
      neg_d = neg_q;
      res_d = res_q;
      done_d = 1'b0;
      trial = {rem_q, quo_q[W-1]} - {1'b0, {(W-fchd_pkg::RATIO_W){1'b0}}, req.divisor};
      unique case (state_q)
         fchd_pkg::DIV_IDLE: begin
            // take the magnitude, remember the sign
            if (req.start) begin
               neg_d = req.dividend[W-1];
               quo_d = req.dividend[W-1] ? W'(-req.dividend) : W'(req.dividend);
               rem_d = '0;
               cnt_d = STEPS;
               state_d = fchd_pkg::DIV_RUN;
            end
         end
         fchd_pkg::DIV_RUN: begin
            // shift in one bit, subtract when it fits
            if (!trial[W]) begin
               rem_d = trial[W-1:0];
               quo_d = {quo_q[W-2:0], 1'b1};
            end else begin
               rem_d = {rem_q[W-2:0], quo_q[W-1]};
               quo_d = {quo_q[W-2:0], 1'b0};
            end
            cnt_d = cnt_q - 7'h01;
            if (cnt_q == 7'h01) begin
               state_d = fchd_pkg::DIV_DONE;
            end
         end
         fchd_pkg::DIV_DONE: begin
            // restore sign, truncate toward zero
            res_d = neg_q ? fchd_pkg::POS_W'(-quo_q) : fchd_pkg::POS_W'(quo_q);
            done_d = 1'b1;
            state_d = fchd_pkg::DIV_IDLE;
         end
         default: begin
            state_d = fchd_pkg::DIV_IDLE;
         end
      endcase
   end

   // registers of the divider
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= fchd_pkg::DIV_IDLE;
         rem_q <= '0;
         quo_q <= '0;
         cnt_q <= '0;
         neg_q <= 1'b0;
         res_q <= fchd_pkg::POS_RESET;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         rem_q <= rem_d;
         quo_q <= quo_d;
         cnt_q <= cnt_d;
         neg_q <= neg_d;
         res_q <= res_d;
         done_q <= done_d;
      end
   end

   assign req.done = done_q;
   assign req.quotient = res_q;
endmodule

// ### hdl/fchd_hybrid_gap.sv
// full-closed scale feedback, ratio conversion and hybrid deviation watch
// Notes on behaviour
// - scale type chosen by setting, 0 to 6
// - quadrature and serial scales both accepted
// - inversion setting flips scale count, feedback counter
// - ratio numerator over denominator, denominator nonzero
// - deviation is encoder minus converted scale position
// - fault when deviation magnitude exceeds gap limit
// - deviation zeroed after programmed motor revolutions
`timescale 1ns/1ns
module fchd_hybrid_gap (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire logic [fchd_pkg::TYPE_W-1:0] scaleTypeSelect,
   input wire logic [fchd_pkg::DIR_W-1:0] scaleDirectionInvert,
   input wire logic [fchd_pkg::RATIO_W-1:0] scaleRatioNumerator,
   input wire logic [fchd_pkg::RATIO_W-1:0] scaleRatioDenominator,
   input wire logic [fchd_pkg::GAP_W-1:0] hybridGapLimit,
   input wire logic [fchd_pkg::REVS_W-1:0] hybridGapClearRevs,
   // quadrature scale pins
   input wire logic scalePhaseA,
   input wire logic scalePhaseB,
   // serial scale position word, same clock domain
   input wire logic serialPosValid,
   input wire logic signed [fchd_pkg::POS_W-1:0] serialPos,
   // motor encoder position and revolution pulse, same clock domain
   input wire logic signed [fchd_pkg::POS_W-1:0] encoderPos,
   input wire logic motorRevPulse,
   // fault acknowledge
   input wire logic faultClear,
   // outputs
   output logic signed [fchd_pkg::POS_W-1:0] scaleFeedbackCount,
   output logic signed [fchd_pkg::POS_W-1:0] hybridDeviation,
   output logic hybridGapFault,
   output logic configError,
   output logic quadOverrun
);
   // synchronisers for the phase pins
   logic [1:0] phaseMeta_q;
   logic [1:0] phaseSync_q;
   logic [1:0] phasePrev_q;
   logic [2:0] phaseWarm_q; // history trusted once it holds real pin levels
   // scale count and deviation state
   logic signed [fchd_pkg::POS_W-1:0] scaleCnt_q, scaleCnt_d;
   logic signed [fchd_pkg::POS_W-1:0] encBase_q, encBase_d;   // encoder at last clear
   logic signed [fchd_pkg::POS_W-1:0] scaleBase_q, scaleBase_d; // converted scale at last clear
   logic signed [fchd_pkg::POS_W-1:0] conv_q, conv_d;          // latest converted scale
   logic signed [fchd_pkg::POS_W-1:0] dev_q, dev_d;
   logic signed [fchd_pkg::POS_W-1:0] fbOut_q, fbOut_d;
   logic fault_q, fault_d;
   logic cfgErr_q, cfgErr_d;
   logic [fchd_pkg::REVS_W-1:0] revCnt_q, revCnt_d;
   logic rebase_q, rebase_d;                                    // rebase on next conversion
   logic [6:0] edgeGap_q, edgeGap_d;                            // cycles since last edge
   logic overrun_q, overrun_d;
   logic busy_q, busy_d;                                        // divide in flight
   // combinational helpers
   logic [1:0] stepDir;
   logic serialMode;
   logic ratioOk;
   logic signed [fchd_pkg::POS_W-1:0] signedCnt;
   logic signed [fchd_pkg::POS_W-1:0] rawDev;
   logic [fchd_pkg::POS_W-1:0] absDev;

   fchd_ratio_if divBus ();

   // magnitude of a signed position
   function automatic logic [fchd_pkg::POS_W-1:0] absPos(input logic signed [fchd_pkg::POS_W-1:0] v);
      absPos = v[fchd_pkg::POS_W-1] ? fchd_pkg::POS_W'(-v) : fchd_pkg::POS_W'(v);
   endfunction

   // quadrature step: 01 count up, 11 count down, 00 none, 10 illegal double step
   function automatic logic [1:0] quadStep(input logic [1:0] prev, input logic [1:0] cur);
      logic [3:0] key;
      key = {prev, cur};
      unique case (key)
         4'b0010, 4'b1011, 4'b1101, 4'b0100: quadStep = 2'b01;
         4'b0001, 4'b0111, 4'b1110, 4'b1000: quadStep = 2'b11;
         4'b0011, 4'b0110, 4'b1001, 4'b1100: quadStep = 2'b10;
         default: quadStep = 2'b00;
      endcase
   endfunction

   // two-flop synchroniser, then history of the clean phases
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phaseMeta_q <= fchd_pkg::QUAD_RESET;
         phaseSync_q <= fchd_pkg::QUAD_RESET;
         phasePrev_q <= fchd_pkg::QUAD_RESET;
         phaseWarm_q <= '0;
      end else begin
         phaseMeta_q <= {scalePhaseA, scalePhaseB};
         phaseSync_q <= phaseMeta_q;
         phasePrev_q <= phaseSync_q;
         // pins may rest anywhere at reset; no false step until history is real
         phaseWarm_q <= {phaseWarm_q[1:0], 1'b1};
      end
   end

   // shared decode of mode, ratio validity and edge direction
   always_comb begin
      serialMode = scaleTypeSelect[fchd_pkg::TYPE_SERIAL_BIT];
      ratioOk = (scaleRatioDenominator != '0) && (scaleRatioDenominator <= fchd_pkg::RATIO_MAX)
         && (scaleRatioNumerator <= fchd_pkg::RATIO_MAX);
      stepDir = phaseWarm_q[2] ? quadStep(phasePrev_q, phaseSync_q) : 2'b00;
      signedCnt = scaleDirectionInvert[fchd_pkg::DIR_COUNT_BIT] ? -scaleCnt_q : scaleCnt_q;
      rawDev = encoderPos - encBase_q - (conv_q - scaleBase_q);
      absDev = absPos(rawDev);
   end

   // next values for count, conversion, deviation and fault
   always_comb begin
      scaleCnt_d = scaleCnt_q;
      encBase_d = encBase_q;
      scaleBase_d = scaleBase_q;
      conv_d = conv_q;
      dev_d = rawDev;
      fbOut_d = scaleDirectionInvert[fchd_pkg::DIR_FEED_BIT] ? -signedCnt : signedCnt;
      fault_d = fault_q;
      revCnt_d = revCnt_q;
      rebase_d = rebase_q;
      edgeGap_d = edgeGap_q;
      overrun_d = overrun_q && !faultClear; // acknowledge first, so a new close edge wins
      busy_d = busy_q;
      // settings outside their ranges flag a configuration error
      cfgErr_d = (scaleTypeSelect > fchd_pkg::TYPE_MAX) || !ratioOk || (hybridGapLimit < fchd_pkg::GAP_MIN)
         || (hybridGapLimit > fchd_pkg::GAP_MAX) || (hybridGapClearRevs > fchd_pkg::REVS_MAX);
      // scale count from the selected source
      if (serialMode) begin
         if (serialPosValid) begin
            scaleCnt_d = serialPos;
         end
      end else if (stepDir == 2'b01) begin
         scaleCnt_d = scaleCnt_q + 32'sh0000_0001;
      end else if (stepDir == 2'b11) begin
         scaleCnt_d = scaleCnt_q - 32'sh0000_0001;
      end
      // edge spacing watch for the quadrature input limit
      if (!serialMode && stepDir != 2'b00) begin
         if (stepDir == 2'b10 || edgeGap_q < 7'(fchd_pkg::QUAD_EDGE_CYC)) begin
            overrun_d = 1'b1;
         end
         edgeGap_d = '0;
      end else if (edgeGap_q != 7'h7f) begin
         edgeGap_d = edgeGap_q + 7'h01;
      end
      // launch a conversion whenever the divider is free and the ratio is valid
      if (!busy_q && ratioOk) begin
         busy_d = 1'b1;
      end
      if (divBus.done) begin
         busy_d = 1'b0;
         conv_d = divBus.quotient;
         if (rebase_q) begin
            scaleBase_d = divBus.quotient;
            encBase_d = encoderPos;
            rebase_d = 1'b0;
         end
      end
      // revolution count; zero disables clearing
      if (motorRevPulse && hybridGapClearRevs != '0) begin
         if (revCnt_q + 7'h01 >= hybridGapClearRevs) begin
            revCnt_d = '0;
            rebase_d = 1'b1;
         end else begin
            revCnt_d = revCnt_q + 7'h01;
         end
      end
      // fault raised on excess, held until acknowledged; set wins over clear
      if (faultClear) begin
         fault_d = 1'b0;
      end
      if (absDev > fchd_pkg::POS_W'(hybridGapLimit) && !rebase_q) begin
         fault_d = 1'b1;
      end
   end

   // registers of the main datapath
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scaleCnt_q <= fchd_pkg::POS_RESET;
         encBase_q <= fchd_pkg::POS_RESET;
         scaleBase_q <= fchd_pkg::POS_RESET;
         conv_q <= fchd_pkg::POS_RESET;
         dev_q <= fchd_pkg::POS_RESET;
         fbOut_q <= fchd_pkg::POS_RESET;
         fault_q <= 1'b0;
         cfgErr_q <= 1'b0;
         revCnt_q <= '0;
         rebase_q <= 1'b1;
         edgeGap_q <= 7'h7f;
         overrun_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         scaleCnt_q <= scaleCnt_d;
         encBase_q <= encBase_d;
         scaleBase_q <= scaleBase_d;
         conv_q <= conv_d;
         dev_q <= dev_d;
         fbOut_q <= fbOut_d;
         fault_q <= fault_d;
         cfgErr_q <= cfgErr_d;
         revCnt_q <= revCnt_d;
         rebase_q <= rebase_d;
         edgeGap_q <= edgeGap_d;
         overrun_q <= overrun_d;
         busy_q <= busy_d;
      end
   end

   // divider request: scale count times numerator over denominator
   assign divBus.start = !busy_q && ratioOk;
   assign divBus.dividend = fchd_pkg::PROD_W'(signedCnt) * $signed({1'b0, scaleRatioNumerator});
   assign divBus.divisor = scaleRatioDenominator;

   fchd_ratio_div fchd_ratio_div_i (
      .clk(clk),
      .rst(rst),
      .req(divBus.divider)
   );

   assign scaleFeedbackCount = fbOut_q;
   assign hybridDeviation = dev_q;
   assign hybridGapFault = fault_q;
   assign configError = cfgErr_q;
   assign quadOverrun = overrun_q;
endmodule

// ### sim/fchd_monitor.sv
// port checker for the hybrid gap block, bound onto its top
`timescale 1ns/1ns
module fchd_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // settings
   input wire logic [fchd_pkg::TYPE_W-1:0] scaleTypeSelect,
   input wire logic [fchd_pkg::DIR_W-1:0] scaleDirectionInvert,
   input wire logic [fchd_pkg::RATIO_W-1:0] scaleRatioNumerator,
   input wire logic [fchd_pkg::RATIO_W-1:0] scaleRatioDenominator,
   input wire logic [fchd_pkg::GAP_W-1:0] hybridGapLimit,
   input wire logic [fchd_pkg::REVS_W-1:0] hybridGapClearRevs,
   // scale inputs and acknowledge
   input wire logic scalePhaseA,
   input wire logic scalePhaseB,
   input wire logic serialPosValid,
   input wire logic signed [fchd_pkg::POS_W-1:0] serialPos,
   input wire logic faultClear,
   // watched outputs
   input wire logic signed [fchd_pkg::POS_W-1:0] scaleFeedbackCount,
   input wire logic hybridGapFault,
   input wire logic configError,
   input wire logic quadOverrun
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // every setting inside its legal range
   wire logic cfgOk = scaleTypeSelect <= fchd_pkg::TYPE_MAX && scaleRatioNumerator <= fchd_pkg::RATIO_MAX
      && scaleRatioDenominator != '0 && scaleRatioDenominator <= fchd_pkg::RATIO_MAX && hybridGapLimit != '0
      && hybridGapLimit <= fchd_pkg::GAP_MAX && hybridGapClearRevs <= fchd_pkg::REVS_MAX;
   // serial word taken while the count is not inverted
   sequence serTake;
      serialPosValid && scaleTypeSelect[fchd_pkg::TYPE_SERIAL_BIT] && !scaleDirectionInvert[fchd_pkg::DIR_COUNT_BIT];
   endsequence
   // upward edge, A leading, in a quadrature mode without inversion
   sequence quadRise;
      $rose(scalePhaseA) && !scalePhaseB && !scaleTypeSelect[fchd_pkg::TYPE_SERIAL_BIT]
         && scaleDirectionInvert == 2'h0;
   endsequence
   // pins stay put while the edge is counted
   sequence pinsQuiet;
      $stable({scalePhaseA, scalePhaseB})[*3];
   endsequence
   AST_CFG_GOOD: assert property (cfgOk |=> !configError)
      else $error("legal settings flagged");
   AST_TYPE_RANGE: assert property (scaleTypeSelect > fchd_pkg::TYPE_MAX |=> configError)
      else $error("scale type out of range not flagged");
   AST_DENOM_ZERO: assert property (scaleRatioDenominator == '0 |=> configError)
      else $error("zero denominator not flagged");
   AST_GAP_ZERO: assert property (hybridGapLimit == '0 |=> configError)
      else $error("zero gap limit not flagged");
   AST_REVS_RANGE: assert property (hybridGapClearRevs > fchd_pkg::REVS_MAX |=> configError)
      else $error("clear count out of range not flagged");
   AST_SERIAL_FEED: assert property (serTake ##1 $stable(scaleDirectionInvert)
      |=> scaleFeedbackCount == ($past(scaleDirectionInvert[fchd_pkg::DIR_FEED_BIT]) ? -$past(serialPos, 2)
      : $past(serialPos, 2)))
      else $error("serial word not shown on feedback count");
   AST_QUAD_UP: assert property (quadRise ##1 pinsQuiet
      |=> scaleFeedbackCount == $past(scaleFeedbackCount, 4) + 1)
      else $error("quadrature up edge not counted");
   AST_FAULT_HOLD: assert property (hybridGapFault && !faultClear |=> hybridGapFault)
      else $error("gap fault dropped without clear");
   AST_OVERRUN_HOLD: assert property (quadOverrun && !faultClear |=> quadOverrun)
      else $error("overrun flag dropped without clear");
endmodule
bind fchd_hybrid_gap fchd_monitor fchd_monitor_i (.clk, .rst, .scaleTypeSelect, .scaleDirectionInvert,
   .scaleRatioNumerator, .scaleRatioDenominator, .hybridGapLimit, .hybridGapClearRevs, .scalePhaseA,
   .scalePhaseB, .serialPosValid, .serialPos, .faultClear, .scaleFeedbackCount, .hybridGapFault,
   .configError, .quadOverrun);

// ### sim/fchd_scale_model.sv
// behavioural quadrature scale and motor encoder facing the block
`timescale 1ns/1ns
module fchd_scale_model (
   // clock
   input wire logic clk,
   // scale pins
   output logic scalePhaseA,
   output logic scalePhaseB,
   // motor encoder position and revolution mark
   output logic signed [fchd_pkg::POS_W-1:0] encoderPos,
   output logic motorRevPulse
);
   int edgeGap = 62; // cycles held between pin edges
   // scale and encoder start at rest
   initial begin
      scalePhaseA = 1'b0;
      scalePhaseB = 1'b0;
      encoderPos = '0;
      motorRevPulse = 1'b0;
   end
   // one edge along the gray walk, A leading B when moving up
   task automatic step(input logic up);
      logic [1:0] s;
      s = {scalePhaseA, scalePhaseB};
      @(posedge clk);
      {scalePhaseA, scalePhaseB} <= up ? {~s[0], s[1]} : {s[0], ~s[1]};
      repeat (edgeGap) @(posedge clk);
   endtask
   // encoder moved by d units
   task automatic move(input int d);
      @(posedge clk);
      encoderPos <= encoderPos + d;
   endtask
   // one revolution mark
   task automatic rev();
      @(posedge clk);
      motorRevPulse <= 1'b1;
      @(posedge clk);
      motorRevPulse <= 1'b0;
   endtask
endmodule

// ### sim/tb_fchd_hybrid_gap.sv
// self-checking bench for the full-closed hybrid gap block
`timescale 1ns/1ns
module tb_fchd_hybrid_gap;
   // clock, reset, pins and pulses
   logic clk, rst, scalePhaseA, scalePhaseB, serialPosValid, motorRevPulse, faultClear, quiet;
   // settings
   logic [fchd_pkg::TYPE_W-1:0] scaleTypeSelect;
   logic [fchd_pkg::DIR_W-1:0] scaleDirectionInvert;
   logic [fchd_pkg::RATIO_W-1:0] scaleRatioNumerator, scaleRatioDenominator;
   logic [fchd_pkg::GAP_W-1:0] hybridGapLimit;
   logic [fchd_pkg::REVS_W-1:0] hybridGapClearRevs;
   // positions and outputs
   logic signed [fchd_pkg::POS_W-1:0] serialPos, encoderPos, scaleFeedbackCount, hybridDeviation, lastFb;
   logic hybridGapFault, configError, quadOverrun;
   logic signed [fchd_pkg::POS_W-1:0] expQ[$]; // expected feedback counts, oldest first
   int mismatches, cmpCount, cnt;
   fchd_hybrid_gap fchd_hybrid_gap_i (.clk, .rst, .scaleTypeSelect, .scaleDirectionInvert, .scaleRatioNumerator,
      .scaleRatioDenominator, .hybridGapLimit, .hybridGapClearRevs, .scalePhaseA, .scalePhaseB, .serialPosValid,
      .serialPos, .encoderPos, .motorRevPulse, .faultClear, .scaleFeedbackCount, .hybridDeviation,
      .hybridGapFault, .configError, .quadOverrun);
   fchd_scale_model fchd_scale_model_i (.clk, .scalePhaseA, .scalePhaseB, .encoderPos, .motorRevPulse);
   // 4 ns clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic closeOut();
      if (mismatches == 0 && cmpCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // takes the oldest note whenever the feedback count moves while quiet is low
   always @(posedge clk) begin
      if (rst) begin
         lastFb <= '0;
      end else if (scaleFeedbackCount !== lastFb) begin
         lastFb <= scaleFeedbackCount;
         if (!quiet) check(scaleFeedbackCount, expQ.size() > 0 ? expQ.pop_front() : lastFb);
      end
   end
   // reset for 8 cycles, notes dropped, then time for the first rebase
   task automatic doReset();
      @(posedge clk);
      rst <= 1'b1;
      expQ.delete();
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (100) @(posedge clk);
   endtask
   // apply all settings, then check the range flag
   task automatic setCfg(input logic [2:0] t, input logic [1:0] d, input logic [23:0] n, input logic [23:0] dn,
         input logic [27:0] g, input logic [6:0] r);
      logic bad;
      bad = t > fchd_pkg::TYPE_MAX || n > fchd_pkg::RATIO_MAX || dn == 0 || dn > fchd_pkg::RATIO_MAX || g == 0;
      bad = bad || g > fchd_pkg::GAP_MAX || r > fchd_pkg::REVS_MAX;
      @(posedge clk);
      {scaleTypeSelect, scaleDirectionInvert, scaleRatioNumerator} <= {t, d, n};
      {scaleRatioDenominator, hybridGapLimit, hybridGapClearRevs} <= {dn, g, r};
      repeat (2) @(posedge clk);
      check(configError, bad);
   endtask
   // random pick among 0, 1 and the values around the top of a range
   function automatic logic [27:0] edgeVal(input logic [27:0] top);
      return $urandom_range(0, 1) ? top - 28'h1 + 28'($urandom_range(0, 2)) : 28'($urandom_range(0, 1));
   endfunction
   // one serial word moved by d, encoder follows in step
   task automatic ser(input int d);
      @(posedge clk);
      serialPos <= serialPos + d;
      serialPosValid <= 1'b1;
      expQ.push_back(scaleDirectionInvert[1] ? -(serialPos + d) : serialPos + d);
      @(posedge clk);
      serialPosValid <= 1'b0;
      fchd_scale_model_i.move(d);
   endtask
   // one-cycle acknowledge
   task automatic clearFault();
      @(posedge clk);
      faultClear <= 1'b1;
      @(posedge clk);
      faultClear <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // let conversions run, then check gap and fault
   task automatic settle(input int dev, input logic flt);
      repeat (150) @(posedge clk);
      check(hybridDeviation, dev);
      check(hybridGapFault, flt);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'h59c5));
      rst <= 1'b1;
      {quiet, serialPosValid, faultClear} <= 3'h0;
      serialPos <= '0;
      {scaleTypeSelect, scaleDirectionInvert, scaleRatioNumerator, scaleRatioDenominator} <= {5'h0, 24'h1, 24'h1};
      {hybridGapLimit, hybridGapClearRevs} <= {28'h3E8, 7'h0};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // settings at and around every range edge
      repeat (40) setCfg(3'($urandom_range(0, 7)), 2'($urandom), 24'(edgeVal(28'h80_0000)),
         24'(edgeVal(28'h80_0000)), edgeVal(28'h800_0000), 7'($urandom_range(99, 101)));
      // quadrature, ratio 8 over 2
      setCfg(3'h0, 2'h0, 24'h8, 24'h2, 28'h3E8, 7'h0);
      doReset();
      cnt = 0;
      for (int i = 0; i < 8; i++) begin
         cnt += i < 6 ? 1 : -1;
         expQ.push_back(cnt);
         fchd_scale_model_i.step(i < 6);
         fchd_scale_model_i.move(i < 6 ? 4 : -4);
      end
      settle(0, 1'b0);
      check(quadOverrun, 1'b0);
      // edges too close together
      quiet <= 1'b1;
      fchd_scale_model_i.edgeGap = 10;
      repeat (4) fchd_scale_model_i.step(1'b1);
      check(quadOverrun, 1'b1);
      clearFault();
      check(quadOverrun, 1'b0);
      fchd_scale_model_i.edgeGap = 62;
      // serial scale, random moves, feedback inversion
      setCfg(3'h1, 2'h0, 24'h1, 24'h1, 28'h3E8, 7'h0);
      doReset();
      quiet <= 1'b0;
      repeat (6) ser($urandom_range(1, 100));
      expQ.push_back(-serialPos);
      setCfg(3'h1, 2'h2, 24'h1, 24'h1, 28'h3E8, 7'h0);
      ser(7);
      expQ.push_back(serialPos);
      setCfg(3'h1, 2'h0, 24'h1, 24'h1, 28'h3E8, 7'h0);
      fchd_scale_model_i.step(1'b1);
      settle(0, 1'b0);
      // gap limit 100, cleared every second revolution
      setCfg(3'h1, 2'h0, 24'h1, 24'h1, 28'h64, 7'h2);
      fchd_scale_model_i.move(100);
      settle(100, 1'b0);
      fchd_scale_model_i.move(1);
      settle(101, 1'b1);
      clearFault();
      check(hybridGapFault, 1'b1);
      fchd_scale_model_i.move(-91);
      settle(10, 1'b1);
      clearFault();
      check(hybridGapFault, 1'b0);
      fchd_scale_model_i.rev();
      settle(10, 1'b0);
      fchd_scale_model_i.rev();
      settle(0, 1'b0);
      // count inversion flips the converted scale, so the gap doubles the position
      expQ.push_back(-serialPos);
      setCfg(3'h1, 2'h1, 24'h1, 24'h1, 28'h1, 7'h2);
      settle(2 * serialPos, 1'b1);
      closeOut();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      closeOut();
   end
endmodule
